// ---- spsf_defs.vh ----
// Offsets, field positions and reset values of the serial port status block
`ifndef SPSF_DEFS_VH
`define SPSF_DEFS_VH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define SPSF_OFF_STATUS 8'h00
`define SPSF_OFF_CTRL 8'h04
`define SPSF_OFF_TXDATA 8'h08
`define SPSF_OFF_RXDATA 8'h0C
`define SPSF_OFF_INT_STAT 8'h10
`define SPSF_OFF_INT_EN 8'h14
`define SPSF_OFF_INT_CLR 8'h18

// ----------------------------------------
// Status register fields
// ----------------------------------------
`define SPSF_ST_SMP 7
`define SPSF_ST_CKE 6
`define SPSF_ST_STOP 4
`define SPSF_ST_START 3

// ----------------------------------------
// Control register fields
// ----------------------------------------
`define SPSF_CT_EN 0
`define SPSF_CT_I2C 1
`define SPSF_CT_MASTER 2
`define SPSF_CT_CKP 3
`define SPSF_CTRL_W 4

// ----------------------------------------
// Interrupt fields
// ----------------------------------------
`define SPSF_IRQ_START 0
`define SPSF_IRQ_STOP 1
`define SPSF_IRQ_BYTE 2
`define SPSF_IRQ_W 3

// ----------------------------------------
// Reset values and counts
// ----------------------------------------
`define SPSF_RST_BYTE 8'h00
`define SPSF_RST_CTRL 4'h0
`define SPSF_RST_IRQ 3'h0
`define SPSF_BITS_LAST 3'h7
`endif

// ---- spsf_pin_sync.v ----
// Three-flop pin synchroniser with agreement filter and edge pulses
`timescale 1ns/1ns
module spsf_pin_sync
(
  // Clock and reset
  input wire ref_clk,
  input wire rst_n,
  // Pin
  input wire pin_in,
  // Filtered level and edges
  output reg level_reg,
  output reg rise_reg,
  output reg fall_reg
);
  reg s1_reg;
  reg s2_reg;
  reg s3_reg;
  reg [3:0] fill_reg;

  always @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s1_reg <= 1'b0;
      s2_reg <= 1'b0;
      s3_reg <= 1'b0;
      fill_reg <= 4'h0;
      level_reg <= 1'b0;
      rise_reg <= 1'b0;
      fall_reg <= 1'b0;
    end
    else
    begin
      s1_reg <= pin_in;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      fill_reg <= {fill_reg[2:0], 1'b1};
      // A change counts once the second and third stages agree
      // No edge until the stages hold pin samples: idle-high pins show none after reset
      rise_reg <= fill_reg[3] && (s2_reg == s3_reg) && s3_reg && !level_reg;
      fall_reg <= fill_reg[3] && (s2_reg == s3_reg) && !s3_reg && level_reg;
      if (s2_reg == s3_reg)
        level_reg <= s3_reg;
    end
  end
endmodule

// ---- spsf_top.v ----
// Serial port status flags: APB registers, SPI edge control, I2C start/stop flags
//
// Summary of operation
// - Clock-edge select 1: SPI transmit bit changes on active-to-idle clock edge.
// - Clock-edge select 0: SPI transmit bit changes on idle-to-active clock edge.
// - In I2C mode clock-edge select 1 enables SMBus input thresholds, 0 disables.
// - In I2C mode start-seen sets on a start condition; reads 0 after reset.
// - Start-seen clears whenever the port-enable bit is cleared.
// - Start-seen returns to 0 once a later stop condition is seen.
// - In I2C mode stop-seen sets on a stop condition; reads 0 after reset.
`timescale 1ns/1ns
`include "spsf_defs.vh"
module spsf_top
(
  // Clock and reset
  input wire ref_clk,
  input wire rst_n,
  // APB slave
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  // SPI pins
  input wire sck_in,
  input wire sdi_in,
  output reg sdo_out,
  output reg sdo_oe,
  // I2C pins
  input wire scl_in,
  input wire sda_in,
  // Level and interrupt outputs
  output reg smbus_level_en,
  output reg irq
);

  // ----------------------------------------
  // Address decode
  // ----------------------------------------
  function addr_known;
    input [7:0] a;
    begin
      addr_known = (a == `SPSF_OFF_STATUS) || (a == `SPSF_OFF_CTRL) ||
        (a == `SPSF_OFF_TXDATA) || (a == `SPSF_OFF_RXDATA) ||
        (a == `SPSF_OFF_INT_STAT) || (a == `SPSF_OFF_INT_EN) ||
        (a == `SPSF_OFF_INT_CLR);
    end
  endfunction

  reg input_sample_phase_reg;
  reg clk_edge_sel_reg;
  reg start_seen_reg;
  reg stop_seen_reg;
  reg [`SPSF_CTRL_W-1:0] ctrl_reg;
  reg [7:0] tx_shift_reg;
  reg [7:0] rx_shift_reg;
  reg [7:0] rx_data_reg;
  reg [2:0] bit_cnt_reg;
  reg [`SPSF_IRQ_W-1:0] int_stat_reg;
  reg [`SPSF_IRQ_W-1:0] int_en_reg;
  reg [31:0] rd_mux;
  reg [`SPSF_IRQ_W-1:0] int_set;
  reg [`SPSF_IRQ_W-1:0] int_stat_next;

  wire sck_rise;
  wire sck_fall;
  wire sdi_lvl;
  wire scl_lvl;
  wire sda_lvl;
  wire sda_rise;
  wire sda_fall;

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  spsf_pin_sync u_sck
  (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .pin_in(sck_in),
    .level_reg(),
    .rise_reg(sck_rise),
    .fall_reg(sck_fall)
  );

  spsf_pin_sync u_sdi
  (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .pin_in(sdi_in),
    .level_reg(sdi_lvl),
    .rise_reg(),
    .fall_reg()
  );

  spsf_pin_sync u_scl
  (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .pin_in(scl_in),
    .level_reg(scl_lvl),
    .rise_reg(),
    .fall_reg()
  );

  spsf_pin_sync u_sda
  (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .pin_in(sda_in),
    .level_reg(sda_lvl),
    .rise_reg(sda_rise),
    .fall_reg(sda_fall)
  );

  // ----------------------------------------
  // Mode and edge selection
  // ----------------------------------------
  wire port_on = ctrl_reg[`SPSF_CT_EN];
  wire i2c_on = port_on && ctrl_reg[`SPSF_CT_I2C];
  wire spi_on = port_on && !ctrl_reg[`SPSF_CT_I2C];
  wire idle_hi = ctrl_reg[`SPSF_CT_CKP];
  wire to_active = idle_hi ? sck_fall : sck_rise;
  wire to_idle = idle_hi ? sck_rise : sck_fall;
  wire tx_edge = clk_edge_sel_reg ? to_idle : to_active;
  wire rx_other = clk_edge_sel_reg ? to_active : to_idle;
  wire late_smp = ctrl_reg[`SPSF_CT_MASTER] && input_sample_phase_reg;
  wire rx_edge = late_smp ? tx_edge : rx_other;
  wire start_cond = i2c_on && sda_fall && scl_lvl;
  wire stop_cond = i2c_on && sda_rise && scl_lvl;

  // ----------------------------------------
  // APB access
  // ----------------------------------------
  wire setup_ph = psel && !penable;
  wire wr_go = psel && penable && pready && pwrite && !pslverr;
  wire wr_status = wr_go && (paddr == `SPSF_OFF_STATUS);
  wire wr_ctrl = wr_go && (paddr == `SPSF_OFF_CTRL);
  wire wr_tx = wr_go && (paddr == `SPSF_OFF_TXDATA);
  wire wr_en = wr_go && (paddr == `SPSF_OFF_INT_EN);
  wire wr_clr = wr_go && (paddr == `SPSF_OFF_INT_CLR);

  always @*
  begin
    rd_mux = 32'h0000_0000;
    case (paddr)
      `SPSF_OFF_STATUS:
      begin
        rd_mux[`SPSF_ST_SMP] = input_sample_phase_reg;
        rd_mux[`SPSF_ST_CKE] = clk_edge_sel_reg;
        rd_mux[`SPSF_ST_STOP] = stop_seen_reg;
        rd_mux[`SPSF_ST_START] = start_seen_reg;
      end
      `SPSF_OFF_CTRL: rd_mux[`SPSF_CTRL_W-1:0] = ctrl_reg;
      `SPSF_OFF_TXDATA: rd_mux[7:0] = tx_shift_reg;
      `SPSF_OFF_RXDATA: rd_mux[7:0] = rx_data_reg;
      `SPSF_OFF_INT_STAT: rd_mux[`SPSF_IRQ_W-1:0] = int_stat_reg;
      `SPSF_OFF_INT_EN: rd_mux[`SPSF_IRQ_W-1:0] = int_en_reg;
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  always @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end
    else
    begin
      pready <= setup_ph;
      pslverr <= setup_ph && !addr_known(paddr);
      prdata <= (setup_ph && !pwrite) ? rd_mux : 32'h0000_0000;
    end
  end

  // ----------------------------------------
  // Software fields
  // ----------------------------------------
  always @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      input_sample_phase_reg <= 1'b0;
      clk_edge_sel_reg <= 1'b0;
      ctrl_reg <= `SPSF_RST_CTRL;
      int_en_reg <= `SPSF_RST_IRQ;
    end
    else
    begin
      if (wr_status)
      begin
        input_sample_phase_reg <= pwdata[`SPSF_ST_SMP];
        clk_edge_sel_reg <= pwdata[`SPSF_ST_CKE];
      end
      if (wr_ctrl)
        ctrl_reg <= pwdata[`SPSF_CTRL_W-1:0];
      if (wr_en)
        int_en_reg <= pwdata[`SPSF_IRQ_W-1:0];
    end
  end

  // ----------------------------------------
  // I2C start and stop flags
  // ----------------------------------------
  always @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      start_seen_reg <= 1'b0;
      stop_seen_reg <= 1'b0;
    end
    else if (!port_on)
    begin
      start_seen_reg <= 1'b0;
      stop_seen_reg <= 1'b0;
    end
    else if (start_cond)
    begin
      start_seen_reg <= 1'b1;
      stop_seen_reg <= 1'b0;
    end
    else if (stop_cond)
    begin
      start_seen_reg <= 1'b0;
      stop_seen_reg <= 1'b1;
    end
  end

  // SMBus thresholds follow the edge select bit only in I2C mode
  always @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      smbus_level_en <= 1'b0;
    else
      smbus_level_en <= i2c_on && clk_edge_sel_reg;
  end

  // ----------------------------------------
  // SPI shifter
  // ----------------------------------------
  wire byte_done = spi_on && rx_edge && (bit_cnt_reg == `SPSF_BITS_LAST);

  always @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      tx_shift_reg <= `SPSF_RST_BYTE;
      rx_shift_reg <= `SPSF_RST_BYTE;
      rx_data_reg <= `SPSF_RST_BYTE;
      bit_cnt_reg <= 3'h0;
      sdo_out <= 1'b0;
      sdo_oe <= 1'b0;
    end
    else
    begin
      sdo_oe <= spi_on;
      if (!spi_on)
        bit_cnt_reg <= 3'h0;
      if (wr_tx)
      begin
        bit_cnt_reg <= 3'h0;
        // First bit must lead the first idle-to-active edge
        if (clk_edge_sel_reg)
        begin
          sdo_out <= pwdata[7];
          tx_shift_reg <= {pwdata[6:0], 1'b0};
        end
        else
          tx_shift_reg <= pwdata[7:0];
      end
      else if (spi_on && tx_edge)
      begin
        sdo_out <= tx_shift_reg[7];
        tx_shift_reg <= {tx_shift_reg[6:0], 1'b0};
      end
      if (spi_on && rx_edge && !wr_tx)
      begin
        rx_shift_reg <= {rx_shift_reg[6:0], sdi_lvl};
        bit_cnt_reg <= bit_cnt_reg + 3'h1;
        if (byte_done)
          rx_data_reg <= {rx_shift_reg[6:0], sdi_lvl};
      end
    end
  end

  // ----------------------------------------
  // Interrupts
  // ----------------------------------------
  always @*
  begin
    int_set = `SPSF_RST_IRQ;
    int_set[`SPSF_IRQ_START] = start_cond;
    int_set[`SPSF_IRQ_STOP] = stop_cond;
    int_set[`SPSF_IRQ_BYTE] = byte_done && !wr_tx;
    // Set wins over a clear in the same cycle
    int_stat_next = int_stat_reg;
    if (wr_clr)
      int_stat_next = int_stat_reg & ~pwdata[`SPSF_IRQ_W-1:0];
    int_stat_next = int_stat_next | int_set;
  end

  always @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      int_stat_reg <= `SPSF_RST_IRQ;
      irq <= 1'b0;
    end
    else
    begin
      int_stat_reg <= int_stat_next;
      irq <= |(int_stat_reg & int_en_reg);
    end
  end

endmodule

// ---- spsf_assertions.sv ----
// Port checker of the serial port status flags block
`timescale 1ns/1ns
module spsf_assertions
(
  // Clock and reset
  input wire ref_clk,
  input wire rst_n,
  // Watched ports
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] prdata,
  input wire pready,
  input wire pslverr,
  input wire sck_in,
  input wire sdo_out,
  input wire sdo_oe,
  input wire smbus_level_en
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  reg sck_prev_reg;
  reg [3:0] quiet_reg;
  // Cycles since the link clock or the bus last moved
  always @(posedge ref_clk or negedge rst_n)
    if (!rst_n)
    begin
      sck_prev_reg <= 1'b0;
      quiet_reg <= 4'h0;
    end
    else
    begin
      sck_prev_reg <= sck_in;
      if (sck_in != sck_prev_reg || psel)
        quiet_reg <= 4'h0;
      else if (quiet_reg != 4'hF)
        quiet_reg <= quiet_reg + 4'h1;
    end
  pready_one_a: assert property (psel && !penable |=> pready)
    else $error("access not answered in one cycle");
  pready_pulse_a: assert property (pready |=> !pready)
    else $error("ready held past one cycle");
  err_ready_a: assert property (pslverr |-> pready)
    else $error("error without ready");
  rdata_idle_a: assert property (!pready |-> prdata == 32'h0000_0000)
    else $error("read data outside access");
  smbus_read_a: assert property (pready && !pwrite && paddr == 8'h00 && !prdata[6]
    |-> !smbus_level_en)
    else $error("level select on with bit clear");
  smbus_mode_a: assert property (smbus_level_en |-> !sdo_oe)
    else $error("level select in link mode");
  flags_excl_a: assert property (pready && !pwrite && paddr == 8'h00
    |-> !(prdata[3] && prdata[4]))
    else $error("both condition flags set");
  sdo_cause_a: assert property ($changed(sdo_out) |-> quiet_reg < 4'hC)
    else $error("data out moved without clock edge");
endmodule
bind spsf_top spsf_assertions spsf_assertions_inst (.ref_clk, .rst_n, .psel, .penable,
  .pwrite, .paddr, .prdata, .pready, .pslverr, .sck_in, .sdo_out, .sdo_oe, .smbus_level_en);

// ---- spsf_peer.sv ----
// Far-side bus peer: link clock, link data and two-wire conditions
`timescale 1ns/1ns
module spsf_peer
(
  // Lines toward the block
  output reg sck_in,
  output reg sdi_in,
  output reg scl_in,
  output reg sda_in,
  // Data from the block
  input wire sdo_out
);
  initial
  begin
    sck_in = 1'b0;
    sdi_in = 1'b0;
    scl_in = 1'b1;
    sda_in = 1'b1;
  end
  // Data moves while clock high: falling is a start, rising a stop
  task i2c_cond(input level);
    begin
      #80 scl_in <= 1'b0;
      #80 sda_in <= ~level;
      #80 scl_in <= 1'b1;
      #80 sda_in <= level;
    end
  endtask
  // Sets the level at which the link clock rests between bytes
  task park(input lvl);
    begin
      sck_in <= lvl;
    end
  endtask
  // One byte, MSB first, 80 ns clock that leaves and returns to its resting level
  task xfer(input [7:0] tx, input cke, output [7:0] rx);
    integer k;
    begin
      for (k = 7; k >= 0; k = k - 1)
      begin
        #20 sdi_in <= tx[k];
        #19 if (!cke && k < 7) rx[k + 1] = sdo_out;
        #1 sck_in <= ~sck_in;
        #35 if (cke) rx[k] = sdo_out;
        #5 sck_in <= ~sck_in;
      end
      #39 if (!cke) rx[0] = sdo_out;
      sdi_in <= ~sdi_in;
    end
  endtask
endmodule

// ---- test_serial_port_status_flags.sv ----
// Self-checking bench of the serial port status flags block
`timescale 1ns/1ns
`include "spsf_defs.vh"
module test_serial_port_status_flags;
  reg ref_clk;
  reg rst_n;
  reg psel;
  reg penable;
  reg pwrite;
  reg [7:0] paddr;
  reg [31:0] pwdata;
  wire [31:0] prdata;
  wire pready;
  wire pslverr;
  wire sck_in;
  wire sdi_in;
  wire sdo_out;
  wire sdo_oe;
  wire scl_in;
  wire sda_in;
  wire smbus_level_en;
  wire irq;
  integer errors;
  integer n_compared;
  integer i;
  reg [31:0] seed;
  reg [31:0] rd;
  reg [7:0] rx;
  reg err;
  spsf_top spsf_top_inst (.ref_clk, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .sck_in, .sdi_in, .sdo_out, .sdo_oe, .scl_in, .sda_in,
    .smbus_level_en, .irq);
  spsf_peer spsf_peer_inst (.sck_in, .sdi_in, .scl_in, .sda_in, .sdo_out);
  function [31:0] next_rand(input [31:0] s);
    reg [31:0] x;
    begin
      x = s ^ (s << 13);
      x = x ^ (x >> 17);
      next_rand = x ^ (x << 5);
    end
  endfunction
  // Status word from edge bits, start and stop flags
  function [31:0] st_exp(input [7:0] w, input s, input p);
    st_exp = {24'h00_0000, w[7:6], 1'b0, p, s, 3'h0};
  endfunction
  task check(input [31:0] seen, input [31:0] expected);
    begin
      n_compared = n_compared + 1;
      if (seen !== expected)
      begin
        errors = errors + 1;
        $display("ERROR %0t seen %h expected %h", $time, seen, expected);
      end
    end
  endtask
  task apb(input wr, input [7:0] addr, input [31:0] data);
    integer n;
    reg ok;
    begin
      @(posedge ref_clk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= addr;
      pwdata <= data;
      @(posedge ref_clk);
      penable <= 1'b1;
      ok = 1'b0;
      // The access ends at the rising edge that sees pready high
      for (n = 0; n < 20 && !ok; n = n + 1)
      begin
        @(posedge ref_clk);
        ok = (pready === 1'b1);
      end
      rd = prdata;
      err = pslverr;
      if (!ok)
        errors = errors + 1;
      psel <= 1'b0;
      penable <= 1'b0;
    end
  endtask
  task complete_run;
    begin
      if (errors == 0 && n_compared > 0)
        $display("NO MISMATCHES");
      else
        $display("MISMATCHES SEEN");
      $finish;
    end
  endtask
  initial
  begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  initial
  begin
    #100000;
    errors = errors + 1;
    complete_run;
  end
  initial
  begin
    errors = 0;
    n_compared = 0;
    seed = 32'h0000_0041;
    rst_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    repeat (12) @(posedge ref_clk);
    rst_n <= 1'b1;
    apb(0, `SPSF_OFF_STATUS, 0);
    check(rd, st_exp(8'h00, 0, 0));
    for (i = 0; i < 4; i = i + 1)
    begin
      seed = next_rand(seed);
      apb(1, `SPSF_OFF_STATUS, seed);
      apb(0, `SPSF_OFF_STATUS, 0);
      check(rd, st_exp(seed[7:0], 0, 0));
    end
    apb(0, 8'h1C, 0);
    check({rd[30:0], err}, 32'h0000_0001);
    apb(1, `SPSF_OFF_CTRL, 3);
    apb(1, `SPSF_OFF_INT_EN, 3);
    for (i = 1; i >= 0; i = i - 1)
    begin
      apb(1, `SPSF_OFF_STATUS, i << 6);
      repeat (2) @(negedge ref_clk);
      check(smbus_level_en, i);
    end
    for (i = 0; i < 3; i = i + 1)
    begin
      spsf_peer_inst.i2c_cond(i == 1);
      repeat (10) @(negedge ref_clk);
      if (i == 2)
        apb(1, `SPSF_OFF_CTRL, 2);
      apb(0, `SPSF_OFF_STATUS, 0);
      check(rd, st_exp(8'h00, i == 0, i == 1));
      @(negedge ref_clk);
      check(irq, 1);
      check(sdo_oe, 0);
    end
    apb(1, `SPSF_OFF_INT_CLR, 7);
    repeat (2) @(negedge ref_clk);
    check(irq, 0);
    apb(1, `SPSF_OFF_INT_EN, 0);
    // Last pass rests the link clock high with idle-high polarity selected
    for (i = 0; i < 4; i = i + 1)
    begin
      spsf_peer_inst.park(i == 3);
      apb(1, `SPSF_OFF_CTRL, i == 2 ? 5 : (i == 3 ? 9 : 1));
      apb(1, `SPSF_OFF_STATUS, i == 2 ? 8'h80 : {i[0], 6'h00});
      seed = next_rand(seed);
      apb(1, `SPSF_OFF_TXDATA, seed[7:0]);
      spsf_peer_inst.xfer(seed[15:8], i[0], rx);
      repeat (10) @(negedge ref_clk);
      apb(0, `SPSF_OFF_RXDATA, 0);
      check(rd, seed[15:8]);
      check(rx, seed[7:0]);
      @(negedge ref_clk);
      check(irq, 0);
      check(sdo_oe, 1);
      check(smbus_level_en, 0);
    end
    apb(1, `SPSF_OFF_INT_EN, 4);
    repeat (2) @(negedge ref_clk);
    check(irq, 1);
    apb(1, `SPSF_OFF_INT_CLR, 4);
    repeat (2) @(negedge ref_clk);
    check(irq, 0);
    complete_run;
  end
endmodule
